// ===== core/uacr_pkg.sv
package uacr_pkg;

    // register addresses
    localparam logic [5:0] UACR_ADDR_TX_DIV   = 6'h00;
    localparam logic [5:0] UACR_ADDR_RX_COUNT = 6'h01;
    localparam logic [5:0] UACR_ADDR_ANALOG   = 6'h02;
    localparam logic [5:0] UACR_ADDR_RX_QUAL  = 6'h03;
    localparam logic [5:0] UACR_ADDR_TX_SHAPE = 6'h04;
    localparam logic [5:0] UACR_ADDR_GAIN_HI  = 6'h05;
    localparam logic [5:0] UACR_ADDR_TIME_LO  = 6'h06;

    // reset values
    localparam logic [7:0] UACR_RST_TX_DIV   = 8'h45;
    localparam logic [7:0] UACR_RST_RX_COUNT = 8'h40;
    localparam logic [7:0] UACR_RST_ANALOG   = 8'h00;
    localparam logic [7:0] UACR_RST_RX_QUAL  = 8'h03;
    localparam logic [7:0] UACR_RST_TX_SHAPE = 8'h1f;
    localparam logic [7:0] UACR_RST_GAIN_HI  = 8'h00;
    localparam logic [7:0] UACR_RST_TIME_LO  = 8'h00;

    // field positions
    localparam int UACR_CMD_RW_BIT  = 6;
    localparam int UACR_BIT_COMMON  = 7;
    localparam int UACR_BIT_MEAS    = 6;
    localparam int UACR_BIT_DAMP    = 5;
    localparam int UACR_BIT_CHAN    = 6;
    localparam int UACR_BIT_SENSOR  = 5;
    localparam int UACR_BIT_TCLK    = 4;
    localparam int UACR_BIT_BLANK   = 3;
    localparam int UACR_BIT_ECHO    = 6;
    localparam int UACR_BIT_TRIG    = 5;
    localparam int UACR_BIT_PGA_BYP = 4;
    localparam int UACR_BIT_LNA_BYP = 3;
    localparam int UACR_BIT_LOW_NOISE_AMP_FEEDBACK  = 2;

    // counts
    localparam logic [6:0] UACR_STOP_FREE_RUN = 7'h20;
    localparam logic [3:0] UACR_TEMP_DIV_LOG2 = 4'h3;
    localparam logic [3:0] UACR_FRAME_BITS    = 4'h8;

    // serial pins
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic sdi;
    } uacr_spi_in_type;

    // decoded configuration
    typedef struct packed {
        logic [6:0] stop_pulse_count;
        logic       common_mode_source;
        logic       measurement_type;
        logic       burst_damping;
        logic       temp_channel_select;
        logic       sensor_type_select;
        logic [8:0] temp_clock_divide;
        logic       power_blanking;
        logic [2:0] echo_threshold;
        logic       echo_mode;
        logic       trigger_edge_select;
        logic [4:0] phase_inversion_position;
        logic [2:0] programmable_amp_gain;
        logic [4:0] programmable_amp_gain_db;
        logic       programmable_amp_bypass;
        logic       low_noise_amp_bypass;
        logic       low_noise_amp_feedback;
        logic [9:0] timing_value;
        logic [2:0] transmit_frequency_divider;
        logic [8:0] transmit_divide;
    } uacr_cfg_type;

endpackage

// ===== core/uacr_regs.sv
`timescale 1ns/10ps
// What this block does
// [R01] receive count 0 gives 32 stop pulses, 1 to 7 give that many
// [R02] host writes zero into reserved bits of receive and analog registers
// [R03] analog bit 7 picks common-mode source, internal at reset
// [R04] analog bit 6 picks time-of-flight or temperature measurement
// [R05] analog bit 5 enables transmit burst damping, off at reset
// [R06] qualification bit 6 picks temperature channels measured
// [R07] qualification bit 5 picks 1000-ohm or 500-ohm sensor
// [R08] qualification bit 4 picks divide by 8 or transmit divider in temperature mode
// [R09] qualification bit 3 enables power blanking using the timing field
// [R10] three-bit echo threshold code, reset to code 3
// [R11] shaping bit 6 picks single or multi echo
// [R12] shaping bit 5 picks rising or falling trigger edge
// [R13] five-bit phase inversion position, reset to 31
// [R14] host should avoid phase inversion positions 0 and 1
// [R15] amplifier gain code gives 3 dB per step, 0 to 21 dB
// [R16] gain register bit 4 bypasses and powers off the amplifier
// [R17] gain register bit 3 bypasses and powers off the low-noise amplifier
// [R18] gain register bit 2 picks capacitive or resistive feedback
// [R19] gain register bits 1:0 are timing field upper bits, reset zero
// [R20] reset loads 00, 03, 1f, 00 into the four registers
// [R21] transmit divider code n divides by 2 to the n+1, default 8
// [R22] timing field low byte sits at address 6
// [R23] serial access: command byte with rw bit and 6-bit address, one data byte
// [R24] every field reads back last written value or reset value
module uacr_regs
    import uacr_pkg::*;
(
    // clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    rst_in,
    // serial pins
    input  wire uacr_pkg::uacr_spi_in_type spi_in,
    output logic                         sdo_out,
    output logic                         sdo_oe_out,
    // configuration to the analog front end
    output uacr_pkg::uacr_cfg_type       cfg_out
);
    import uacr_pkg::*;

    typedef enum logic [1:0] {UACR_IDLE, UACR_CMD, UACR_DATA, UACR_DONE} uacr_state_type;

    // pin synchronisers
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic       sclk_prev_r;
    logic       sclk_s;
    logic       cs_n_s;
    logic       sdi_s;
    logic       sclk_rise;
    logic       sclk_fall;

    // serial engine
    uacr_state_type state_r;
    uacr_state_type state_nxt;
    logic [3:0]     bit_cnt_r;
    logic [3:0]     bit_cnt_nxt;
    logic [7:0]     shift_r;
    logic [7:0]     shift_nxt;
    logic           is_read_r;
    logic           is_read_nxt;
    logic [5:0]     addr_r;
    logic [5:0]     addr_nxt;
    logic [7:0]     rd_shift_r;
    logic [7:0]     rd_shift_nxt;
    logic           sdo_r;
    logic           sdo_nxt;
    logic           oe_r;
    logic           oe_nxt;
    logic           wr_stb;
    logic [7:0]     wr_byte;

    // register bank
    logic [7:0] tx_div_r;
    logic [7:0] rx_count_r;
    logic [7:0] analog_mode_config_r;
    logic [7:0] receive_qualification_config_r;
    logic [7:0] transmit_shaping_config_r;
    logic [7:0] gain_and_timing_high_r;
    logic [7:0] time_lo_r;
    logic [7:0] tx_div_nxt;
    logic [7:0] rx_count_nxt;
    logic [7:0] analog_nxt;
    logic [7:0] rx_qual_nxt;
    logic [7:0] tx_shape_nxt;
    logic [7:0] gain_hi_nxt;
    logic [7:0] time_lo_nxt;
    logic [7:0] rd_data;

    uacr_cfg_type cfg_r;
    uacr_cfg_type cfg_nxt;

    // two flip-flops on every pin
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sync1_r     <= 3'h2;
            sync2_r     <= 3'h2;
            sclk_prev_r <= 1'b0;
        end
        else
        begin
            sync1_r     <= spi_in;
            sync2_r     <= sync1_r;
            sclk_prev_r <= sync2_r[2];
        end
    end

    assign sclk_s    = sync2_r[2];
    assign cs_n_s    = sync2_r[1];
    assign sdi_s     = sync2_r[0];
    assign sclk_rise = sclk_s & ~sclk_prev_r;
    assign sclk_fall = ~sclk_s & sclk_prev_r;

    // read mux
    always_comb
    begin
        unique case (addr_r)
            UACR_ADDR_TX_DIV:   rd_data = tx_div_r;
            UACR_ADDR_RX_COUNT: rd_data = rx_count_r;
            UACR_ADDR_ANALOG:   rd_data = analog_mode_config_r;
            UACR_ADDR_RX_QUAL:  rd_data = receive_qualification_config_r;
            UACR_ADDR_TX_SHAPE: rd_data = transmit_shaping_config_r;
            UACR_ADDR_GAIN_HI:  rd_data = gain_and_timing_high_r;
            UACR_ADDR_TIME_LO:  rd_data = time_lo_r;
            default:            rd_data = 8'h00;
        endcase
    end

    // serial engine, mode 0: sample on rise, shift out on fall
    always_comb
    begin
        state_nxt    = state_r;
        bit_cnt_nxt  = bit_cnt_r;
        shift_nxt    = shift_r;
        is_read_nxt  = is_read_r;
        addr_nxt     = addr_r;
        rd_shift_nxt = rd_shift_r;
        sdo_nxt      = sdo_r;
        oe_nxt       = oe_r;
        wr_stb       = 1'b0;
        wr_byte      = 8'h00;
        if (cs_n_s)
        begin
            state_nxt   = UACR_IDLE;
            oe_nxt      = 1'b0;
            sdo_nxt     = 1'b0;
        end
        else
        begin
            unique case (state_r)
                UACR_IDLE:
                begin
                    state_nxt   = UACR_CMD;
                    bit_cnt_nxt = 4'h0;
                end
                UACR_CMD:
                begin
                    if (sclk_rise)
                    begin
                        shift_nxt   = {shift_r[6:0], sdi_s};
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                        if (bit_cnt_r == UACR_FRAME_BITS - 4'h1)
                        begin
                            // command byte: reserved, rw, 6-bit address [R23]
                            is_read_nxt  = ~shift_nxt[UACR_CMD_RW_BIT];
                            addr_nxt     = shift_nxt[5:0];
                            bit_cnt_nxt  = 4'h0;
                            state_nxt    = UACR_DATA;
                        end
                    end
                end
                UACR_DATA:
                begin
                    if (sclk_fall && is_read_r)
                    begin
                        oe_nxt = 1'b1;
                        if (bit_cnt_r == 4'h0)
                        begin
                            // first data fall fetches the addressed register
                            sdo_nxt      = rd_data[7];
                            rd_shift_nxt = {rd_data[6:0], 1'b0};
                        end
                        else
                        begin
                            sdo_nxt      = rd_shift_r[7];
                            rd_shift_nxt = {rd_shift_r[6:0], 1'b0};
                        end
                    end
                    if (sclk_rise)
                    begin
                        shift_nxt   = {shift_r[6:0], sdi_s};
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                        if (bit_cnt_r == UACR_FRAME_BITS - 4'h1)
                        begin
                            wr_stb    = ~is_read_r; // [R23]
                            wr_byte   = shift_nxt;
                            state_nxt = UACR_DONE;
                        end
                    end
                end
                UACR_DONE:
                begin
                    if (sclk_fall)
                    begin
                        oe_nxt = 1'b0;
                    end
                end
            endcase
        end
    end

    // register writes; all bits stored so reads return them [R24]
    always_comb
    begin
        tx_div_nxt   = tx_div_r;
        rx_count_nxt = rx_count_r;
        analog_nxt   = analog_mode_config_r;
        rx_qual_nxt  = receive_qualification_config_r;
        tx_shape_nxt = transmit_shaping_config_r;
        gain_hi_nxt  = gain_and_timing_high_r;
        time_lo_nxt  = time_lo_r;
        if (wr_stb)
        begin
            unique case (addr_r)
                UACR_ADDR_TX_DIV:   tx_div_nxt   = wr_byte;
                UACR_ADDR_RX_COUNT: rx_count_nxt = wr_byte;
                UACR_ADDR_ANALOG:   analog_nxt   = wr_byte;
                UACR_ADDR_RX_QUAL:  rx_qual_nxt  = wr_byte;
                UACR_ADDR_TX_SHAPE: tx_shape_nxt = wr_byte;
                UACR_ADDR_GAIN_HI:  gain_hi_nxt  = wr_byte;
                UACR_ADDR_TIME_LO:  time_lo_nxt  = wr_byte; // [R22]
                default:            time_lo_nxt  = time_lo_r;
            endcase
        end
    end

    // decode of fields onto the analog controls
    always_comb
    begin
        // code 0 means free run with 32 pulses [R01]
        if (rx_count_r[2:0] == 3'h0)
        begin
            cfg_nxt.stop_pulse_count = UACR_STOP_FREE_RUN; // [R01]
        end
        else
        begin
            cfg_nxt.stop_pulse_count = {4'h0, rx_count_r[2:0]}; // [R01]
        end
        cfg_nxt.common_mode_source  = analog_mode_config_r[UACR_BIT_COMMON]; // [R03]
        cfg_nxt.measurement_type    = analog_mode_config_r[UACR_BIT_MEAS]; // [R04]
        cfg_nxt.burst_damping       = analog_mode_config_r[UACR_BIT_DAMP]; // [R05]
        cfg_nxt.temp_channel_select = receive_qualification_config_r[UACR_BIT_CHAN]; // [R06]
        cfg_nxt.sensor_type_select  = receive_qualification_config_r[UACR_BIT_SENSOR]; // [R07]
        cfg_nxt.transmit_frequency_divider = tx_div_r[7:5];
        cfg_nxt.transmit_divide = 9'h002 << tx_div_r[7:5]; // [R21]
        if (receive_qualification_config_r[UACR_BIT_TCLK])
        begin
            cfg_nxt.temp_clock_divide = 9'h002 << tx_div_r[7:5]; // [R08]
        end
        else
        begin
            cfg_nxt.temp_clock_divide = 9'h001 << UACR_TEMP_DIV_LOG2; // [R08]
        end
        cfg_nxt.power_blanking = receive_qualification_config_r[UACR_BIT_BLANK]; // [R09]
        cfg_nxt.echo_threshold = receive_qualification_config_r[2:0]; // [R10]
        cfg_nxt.echo_mode      = transmit_shaping_config_r[UACR_BIT_ECHO]; // [R11]
        cfg_nxt.trigger_edge_select = transmit_shaping_config_r[UACR_BIT_TRIG]; // [R12]
        cfg_nxt.phase_inversion_position = transmit_shaping_config_r[4:0]; // [R13]
        cfg_nxt.programmable_amp_gain = gain_and_timing_high_r[7:5];
        cfg_nxt.programmable_amp_gain_db =
            {2'h0, gain_and_timing_high_r[7:5]} * 5'h03; // [R15]
        cfg_nxt.programmable_amp_bypass = gain_and_timing_high_r[UACR_BIT_PGA_BYP]; // [R16]
        cfg_nxt.low_noise_amp_bypass    = gain_and_timing_high_r[UACR_BIT_LNA_BYP]; // [R17]
        cfg_nxt.low_noise_amp_feedback  = gain_and_timing_high_r[UACR_BIT_LOW_NOISE_AMP_FEEDBACK]; // [R18]
        cfg_nxt.timing_value = {gain_and_timing_high_r[1:0], time_lo_r}; // [R19] [R22]
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_r    <= UACR_IDLE;
            bit_cnt_r  <= 4'h0;
            shift_r    <= 8'h00;
            is_read_r  <= 1'b0;
            addr_r     <= 6'h00;
            rd_shift_r <= 8'h00;
            sdo_r      <= 1'b0;
            oe_r       <= 1'b0;
            tx_div_r   <= UACR_RST_TX_DIV;
            rx_count_r <= UACR_RST_RX_COUNT;
            analog_mode_config_r           <= UACR_RST_ANALOG; // [R20]
            receive_qualification_config_r <= UACR_RST_RX_QUAL; // [R20]
            transmit_shaping_config_r      <= UACR_RST_TX_SHAPE; // [R20]
            gain_and_timing_high_r         <= UACR_RST_GAIN_HI; // [R20]
            time_lo_r  <= UACR_RST_TIME_LO;
            cfg_r      <= '0;
        end
        else
        begin
            state_r    <= state_nxt;
            bit_cnt_r  <= bit_cnt_nxt;
            shift_r    <= shift_nxt;
            is_read_r  <= is_read_nxt;
            addr_r     <= addr_nxt;
            rd_shift_r <= rd_shift_nxt;
            sdo_r      <= sdo_nxt;
            oe_r       <= oe_nxt;
            tx_div_r   <= tx_div_nxt;
            rx_count_r <= rx_count_nxt;
            analog_mode_config_r           <= analog_nxt;
            receive_qualification_config_r <= rx_qual_nxt;
            transmit_shaping_config_r      <= tx_shape_nxt;
            gain_and_timing_high_r         <= gain_hi_nxt;
            time_lo_r  <= time_lo_nxt;
            cfg_r      <= cfg_nxt;
        end
    end

    assign sdo_out    = sdo_r;
    assign sdo_oe_out = oe_r;
    assign cfg_out    = cfg_r;

endmodule

// ===== bench/uacr_regs_sva.sv
`timescale 1ns/10ps
module uacr_regs_chk
    import uacr_pkg::*;
(
    // clock and reset
    input  wire logic                      clk_in,
    input  wire logic                      rst_in,
    // serial pins
    input  wire uacr_pkg::uacr_spi_in_type spi_in,
    input  wire logic                      sdo_out,
    input  wire logic                      sdo_oe_out,
    // decoded configuration
    input  wire uacr_pkg::uacr_cfg_type    cfg_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    chk_reset_decode: assert property (
        $fell(rst_in) |=> cfg_out.stop_pulse_count == 7'h20 && cfg_out.echo_threshold == 3'h3
            && cfg_out.phase_inversion_position == 5'h1f && cfg_out.transmit_divide == 9'h008)
        else $error("decoded config wrong after reset");
    chk_gain_steps: assert property (
        cfg_out.programmable_amp_gain_db == 5'(cfg_out.programmable_amp_gain * 3))
        else $error("gain in dB not three per code");
    chk_stop_count: assert property (
        !$past(rst_in) |-> cfg_out.stop_pulse_count == 7'h20
            || (cfg_out.stop_pulse_count != 7'h00 && cfg_out.stop_pulse_count < 7'h08))
        else $error("stop pulse count out of range");
    chk_tx_divide: assert property (
        !$past(rst_in) |-> cfg_out.transmit_divide
            == (9'h002 << cfg_out.transmit_frequency_divider))
        else $error("transmit divide not two to code plus one");
    chk_temp_divide: assert property (
        !$past(rst_in) |-> cfg_out.temp_clock_divide == 9'h008
            || cfg_out.temp_clock_divide == cfg_out.transmit_divide)
        else $error("temperature divide neither 8 nor transmit divide");
    chk_idle_quiet: assert property (
        spi_in.cs_n [*5] |-> !sdo_oe_out)
        else $error("data out driven while deselected");
    chk_cfg_hold: assert property (
        spi_in.cs_n [*8] |-> $stable(cfg_out))
        else $error("config changed without a frame");
    chk_oe_in_frame: assert property (
        $rose(sdo_oe_out) |-> !$past(spi_in.cs_n))
        else $error("data out enabled outside a frame");
endmodule

bind uacr_regs uacr_regs_chk u_chk (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .spi_in     (spi_in),
    .sdo_out    (sdo_out),
    .sdo_oe_out (sdo_oe_out),
    .cfg_out    (cfg_out)
);

// ===== bench/uacr_host_model.sv
`timescale 1ns/10ps
module uacr_host_model
    import uacr_pkg::*;
(
    // clock
    input  wire logic                 clk_in,
    // serial pins
    output uacr_pkg::uacr_spi_in_type spi_out,
    input  wire logic                 sdo_in,
    input  wire logic                 sdo_oe_in
);
    int half = 6;

    initial spi_out = '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    // one frame msb first, cut short after nbits
    task automatic xfer(input logic [15:0] frame, input int nbits,
                        output logic [7:0] rd, output logic oe_seen);
        rd = 8'h00;
        oe_seen = 1'b1;
        spi_out.cs_n = 1'b0;
        for (int i = 15; i >= 16 - nbits; i--)
        begin
            spi_out.sdi = frame[i];
            wait_clk(half);
            spi_out.sclk = 1'b1;
            if (i < 8)
            begin
                rd[i] = sdo_in;
                oe_seen = oe_seen & sdo_oe_in;
            end
            wait_clk(half);
            spi_out.sclk = 1'b0;
        end
        wait_clk(half);
        spi_out.cs_n = 1'b1;
        spi_out.sdi = ~spi_out.sdi;
        wait_clk(half);
    endtask
endmodule

// ===== bench/tb.sv
`timescale 1ns/10ps
module tb;
    import uacr_pkg::*;
    logic            clk_in = 1'b0;
    logic            rst_in = 1'b1;
    uacr_spi_in_type spi;
    logic            sdo_out;
    logic            sdo_oe_out;
    uacr_cfg_type    cfg_out;
    int              bad_count = 0;
    int              n_checks = 0;

    always #50 clk_in = ~clk_in;

    uacr_regs dut (.clk_in(clk_in), .rst_in(rst_in), .spi_in(spi), .sdo_out(sdo_out),
                   .sdo_oe_out(sdo_oe_out), .cfg_out(cfg_out));
    uacr_host_model host (.clk_in(clk_in), .spi_out(spi), .sdo_in(sdo_out),
                          .sdo_oe_in(sdo_oe_out));

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        n_checks++;
        if (seen !== want)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic wr(input logic [5:0] addr, input logic [7:0] val);
        logic [7:0] rd;
        logic       oe;
        host.xfer({2'b01, addr, val}, 16, rd, oe);
        check(oe, 1'b0);
    endtask

    task automatic rd_chk(input logic [5:0] addr, input logic [7:0] want);
        logic [7:0] rd;
        logic       oe;
        host.xfer({2'b00, addr, 8'h00}, 16, rd, oe);
        check(rd, want);
        check(oe, 1'b1);
    endtask

    task automatic t_reset_values();
        logic [7:0] want [7] = '{8'h45, 8'h40, 8'h00, 8'h03, 8'h1f, 8'h00, 8'h00};
        for (int a = 0; a < 7; a++)
            rd_chk(a[5:0], want[a]);
        check(cfg_out.stop_pulse_count, 7'h20);
        check(cfg_out.transmit_divide, 9'h008);
        check({cfg_out.common_mode_source, cfg_out.measurement_type,
               cfg_out.burst_damping, cfg_out.sensor_type_select}, 4'h0);
        $display("test reset_values done");
    endtask

    task automatic t_fields();
        wr(UACR_ADDR_ANALOG, 8'he0);
        check({cfg_out.common_mode_source, cfg_out.measurement_type,
               cfg_out.burst_damping}, 3'h7);
        wr(UACR_ADDR_RX_QUAL, 8'h7d);
        check({cfg_out.temp_channel_select, cfg_out.sensor_type_select,
               cfg_out.power_blanking, cfg_out.echo_threshold}, 6'h3d);
        wr(UACR_ADDR_TX_DIV, 8'he5);
        check(cfg_out.transmit_divide, 9'h100);
        check(cfg_out.transmit_frequency_divider, 3'h7);
        check(cfg_out.temp_clock_divide, 9'h100);
        wr(UACR_ADDR_RX_QUAL, 8'h03);
        check(cfg_out.temp_clock_divide, 9'h008);
        wr(UACR_ADDR_TX_SHAPE, 8'h62);
        check({cfg_out.echo_mode, cfg_out.trigger_edge_select,
               cfg_out.phase_inversion_position}, 7'h62);
        wr(UACR_ADDR_GAIN_HI, 8'hff);
        wr(UACR_ADDR_TIME_LO, 8'h5a);
        check({cfg_out.programmable_amp_bypass, cfg_out.low_noise_amp_bypass,
               cfg_out.low_noise_amp_feedback}, 3'h7);
        check(cfg_out.timing_value, 10'h35a);
        rd_chk(UACR_ADDR_GAIN_HI, 8'hff);
        $display("test fields done");
    endtask

    task automatic t_codes();
        for (int c = 0; c < 8; c++)
        begin
            wr(UACR_ADDR_RX_COUNT, {5'h08, c[2:0]});
            check(cfg_out.stop_pulse_count, (c == 0) ? 7'h20 : c[6:0]);
            wr(UACR_ADDR_GAIN_HI, {c[2:0], 5'h00});
            check(cfg_out.programmable_amp_gain_db, c[4:0] * 5'd3);
            check(cfg_out.programmable_amp_gain, c[2:0]);
            wr(UACR_ADDR_RX_QUAL, {5'h00, c[2:0]});
            check(cfg_out.echo_threshold, c[2:0]);
        end
        $display("test codes done");
    endtask

    task automatic t_refused();
        logic [7:0] rd;
        logic       oe;
        wr(6'h07, 8'hff);
        rd_chk(6'h07, 8'h00);
        host.xfer({2'b01, UACR_ADDR_ANALOG, 8'h00}, 12, rd, oe);
        rd_chk(UACR_ADDR_ANALOG, 8'he0);
        $display("test refused done");
    endtask

    task automatic t_midreset();
        rst_in = 1'b1;
        @(negedge clk_in);
        check(|cfg_out, 1'b0);
        check({sdo_out, sdo_oe_out}, 2'h0);
        rst_in = 1'b0;
        repeat (4) @(negedge clk_in);
        rd_chk(UACR_ADDR_TX_SHAPE, 8'h1f);
        check(cfg_out.phase_inversion_position, 5'h1f);
        $display("test midreset done");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (2) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (4) @(negedge clk_in);
        t_reset_values();
        t_fields();
        t_codes();
        t_refused();
        t_midreset();
        stop_test();
    end

    initial
    begin
        repeat (20000) @(posedge clk_in);
        bad_count++;
        stop_test();
    end
endmodule
